// File: pkg/adc_port_pkg.sv
// Purpose: Shared constants and carrier types for the converter serial host port.
// Assumes: Core clock at 125 MHz samples every input pin of the serial link (select, clock, data in).
// Notes:   Result and command words are shifted most significant bit first.
package adc_port_pkg;

    // -------------------------------------------------------------------
    // Widths and counts
    // -------------------------------------------------------------------
    localparam int          RESULT_W     = 16;           // Conversion result width
    localparam int          CMD_W        = 8;            // Received command byte width
    localparam int          SYNC_STAGES  = 2;            // Flip-flops in each pin synchroniser
    localparam logic [2:0]  PIN_RST      = 3'h7;         // Idle pin levels: select high, clocks high
    localparam logic [15:0] RESULT_RST   = 16'h0000;     // Result holding value after reset
    localparam logic [7:0]  CMD_RST      = 8'h00;        // Command byte value after reset

    // -------------------------------------------------------------------
    // Carrier types
    // -------------------------------------------------------------------
    // Synchronised link pins
    typedef struct packed {
        logic cs_n;                                      // Chip select, active low
        logic sclk;                                      // Serial clock
        logic sdi;                                       // Serial data in
    } link_pins_s;

    // Serial data out level with its output enable
    typedef struct packed {
        logic o;                                         // Output level
        logic oe;                                        // Output enable, high while driven
    } tri_pin_s;

    // Shifter state
    typedef enum logic [1:0] {
        IDLE  = 2'b01,                                   // Deselected, shift state frozen
        FRAME = 2'b10                                    // Selected, shifting
    } frame_e;

endpackage

// File: rtl/pin_sync.sv
// Purpose: Two-flop synchroniser for a group of pins.
// Assumes: Inputs are asynchronous to clk.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/100ps
module pin_sync
    import adc_port_pkg::*;
#(
    parameter int          W         = 3,
    parameter logic [2:0]  RST_VALUE = PIN_RST
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta;                                  // First stage, read by q only

    // Two stages on the core clock
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta <= RST_VALUE[W-1:0];
            q    <= RST_VALUE[W-1:0];
        end else if (ce) begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule // pin_sync

// File: rtl/adc_serial_port.sv
// Purpose: Serial host port of a multichannel converter, pin side.
// Assumes: Host is the serial master; serial clock idles high, sampled by clk.
// Notes:   Serial clock period well above four core cycles; command bytes go to core.
//
// Operation
// - Sample serial input on rising clock
// - Shift output bit on falling clock
// - Ignore clock and input while deselected
// - Output high impedance while deselected
// - Raise ready strobe in internal clock
// - Ready strobe low in external clock
// - Ready strobe always driven
`timescale 1ns/100ps
module adc_serial_port
    import adc_port_pkg::*;
#(
    parameter int RES_W = RESULT_W,
    parameter int CMD_WIDTH = CMD_W
) (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 ce,
    input  wire logic                 cs_n,
    input  wire logic                 sclk,
    input  wire logic                 sdi,
    output logic                      sdo,
    output logic                      sdo_oe,
    output logic                      result_ready_strobe,
    input  wire logic                 int_clock_mode,
    input  wire logic                 result_valid,
    input  wire logic [RES_W-1:0]     result_data,
    output logic      [CMD_WIDTH-1:0] cmd_byte,
    output logic                      cmd_valid
);

    // -------------------------------------------------------------------
    // Pin synchronisation
    // -------------------------------------------------------------------
    link_pins_s pins_raw;                                // Raw pin group
    link_pins_s pins;                                    // Synchronised pin group
    logic       sclk_q;                                  // Previous synchronised clock
    logic       cs_n_q;                                  // Previous synchronised select

    assign pins_raw = '{cs_n: cs_n, sclk: sclk, sdi: sdi};

    pin_sync #(
        .W         (3),
        .RST_VALUE (PIN_RST)
    ) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .d     (pins_raw),
        .q     (pins)
    );

    // Edge history of the synchronised pins
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sclk_q <= 1'b1;
            cs_n_q <= 1'b1;
        end else if (ce) begin
            sclk_q <= pins.sclk;
            cs_n_q <= pins.cs_n;
        end
    end

    // -------------------------------------------------------------------
    // Edge decode
    // -------------------------------------------------------------------
    wire selected  = !pins.cs_n;                         // Frame open
    wire sclk_rise = selected && pins.sclk && !sclk_q;
    wire sclk_fall = selected && !pins.sclk && sclk_q;
    wire cs_fall   = selected && cs_n_q;                 // Frame start

    // -------------------------------------------------------------------
    // Frame state
    // -------------------------------------------------------------------
    frame_e state;                                       // Current frame state
    frame_e next_state;                                  // Next frame state

    // Follow chip select
    always_comb begin
        unique case (state)
            IDLE:    next_state = selected ? FRAME : IDLE;
            FRAME:   next_state = selected ? FRAME : IDLE;
            default: next_state = IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= IDLE;
        end else if (ce) begin
            state <= next_state;
        end
    end

    // -------------------------------------------------------------------
    // Receive shifter
    // -------------------------------------------------------------------
    logic [CMD_WIDTH-1:0]         rx_shift;              // Incoming bits
    logic [$clog2(CMD_WIDTH)-1:0] rx_count;              // Bits in current byte
    wire                          rx_last = (rx_count == ($clog2(CMD_WIDTH))'(CMD_WIDTH - 1));
    wire  [CMD_WIDTH-1:0]         next_rx = {rx_shift[CMD_WIDTH-2:0], pins.sdi};

    // Sample input on each rising serial clock while selected
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rx_shift  <= CMD_RST;
            rx_count  <= '0;
            cmd_byte  <= CMD_RST;
            cmd_valid <= 1'b0;
        end else if (ce) begin
            cmd_valid <= 1'b0;
            if (cs_fall) begin
                rx_count <= '0;                          // Byte alignment restarts per frame
            end else if (sclk_rise && state == FRAME) begin
                rx_shift <= next_rx;
                rx_count <= rx_count + 1'b1;
                if (rx_last) begin
                    cmd_byte  <= next_rx;
                    cmd_valid <= 1'b1;
                    rx_count  <= '0;
                end
            end
        end
    end

    // -------------------------------------------------------------------
    // Result holding and ready strobe
    // -------------------------------------------------------------------
    logic [RES_W-1:0] result_hold;                       // Last result from core
    logic [RES_W-1:0] tx_shift;                          // Outgoing bits
    logic             ready;                             // Result waiting to be read

    // Latch results; a new result wins over the read clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            result_hold <= RESULT_RST;
            ready       <= 1'b0;
        end else if (ce) begin
            if (result_valid) begin
                result_hold <= result_data;
                ready       <= 1'b1;
            end else if (cs_fall) begin
                ready       <= 1'b0;                     // Read begins, strobe drops
            end
        end
    end

    // Strobe driven always, low in external clock mode
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            result_ready_strobe <= 1'b0;
        end else if (ce) begin
            result_ready_strobe <= int_clock_mode && ready;
        end
    end

    // -------------------------------------------------------------------
    // Transmit shifter
    // -------------------------------------------------------------------
    // Load at frame start, advance on falling serial clock
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tx_shift <= RESULT_RST;
            sdo      <= 1'b0;
        end else if (ce) begin
            if (cs_fall) begin
                tx_shift <= result_hold;
                sdo      <= 1'b0;
            end else if (sclk_fall && state == FRAME) begin
                sdo      <= tx_shift[RES_W-1];
                tx_shift <= {tx_shift[RES_W-2:0], 1'b0};
            end
        end
    end

    // Output enable follows synchronised select
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sdo_oe <= 1'b0;
        end else if (ce) begin
            sdo_oe <= selected;
        end
    end

endmodule // adc_serial_port

// File: testbench/adc_serial_port_checker.sv
// Purpose: Port assertions for the converter serial host port.
// Assumes: Clock enable held high; link pins sampled by clk.
// Notes:   Pin lag of three core cycles is allowed for.
`timescale 1ns/100ps
module adc_serial_port_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic sdo,
    input wire logic sdo_oe,
    input wire logic result_ready_strobe,
    input wire logic int_clock_mode,
    input wire logic result_valid,
    input wire logic cmd_valid
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ---------------------------------------------------------------
    // Pin checks
    // ---------------------------------------------------------------
    chk_oe_off: assert property (cs_n [*5] |-> !sdo_oe)
        else $error("sdo driven while deselected");
    chk_oe_on: assert property (!cs_n [*5] |-> sdo_oe)
        else $error("sdo released while selected");
    chk_sdo_hold: assert property ((sclk && !cs_n) [*7] |-> $stable(sdo))
        else $error("sdo moved without a falling clock");
    chk_cmd_idle: assert property (cs_n [*6] |-> !cmd_valid)
        else $error("byte taken while deselected");
    // Byte ends one cycle after a rise seen through sync and edge flops
    chk_cmd_timing: assert property (cmd_valid
        |-> $past(sclk, 3) && !$past(sclk, 4) && !$past(cs_n, 3))
        else $error("byte done off a rising clock");
    // ---------------------------------------------------------------
    // Strobe checks
    // ---------------------------------------------------------------
    chk_strobe_ext: assert property (!int_clock_mode [*2] |-> !result_ready_strobe)
        else $error("strobe high in external mode");
    // Ready flag sets on the result edge, strobe register follows one edge later
    chk_strobe_set: assert property (result_valid && int_clock_mode ##1 int_clock_mode
        |=> result_ready_strobe)
        else $error("strobe missing after result");
    // A rise comes from a result two edges back, or from entering internal mode
    chk_strobe_cause: assert property ($rose(result_ready_strobe)
        |-> $past(result_valid, 2) || !$past(int_clock_mode, 2))
        else $error("strobe rose without result");
endmodule  // adc_serial_port_checker

bind adc_serial_port adc_serial_port_checker adc_serial_port_checker_inst (.clk(clk),
    .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .sdo(sdo), .sdo_oe(sdo_oe),
    .result_ready_strobe(result_ready_strobe), .int_clock_mode(int_clock_mode),
    .result_valid(result_valid), .cmd_valid(cmd_valid));

// File: testbench/adc_host_model.sv
// Purpose: Serial master standing in for the host controller.
// Assumes: Serial clock idles high; 125 ns link period.
// Notes:   A released data line shows the inverse of its last level.
`timescale 1ns/100ps
module adc_host_model (
    output logic      cs_n,
    output logic      sclk,
    output logic      sdi,
    input  wire logic sdo,
    input  wire logic sdo_oe
);
    logic last_sdo;  // Last level the port drove
    logic sdo_wire;  // Level the host sees on the line
    assign sdo_wire = sdo_oe ? sdo : ~last_sdo;
    // Remember the driven level
    always @* if (sdo_oe) last_sdo = sdo;
    // Idle pins
    initial begin
        cs_n = 1'b1;
        sclk = 1'b1;
        sdi = 1'b0;
        last_sdo = 1'b0;
    end
    // One framed transfer, word out on sdi and word in from sdo
    // The extra 0.1 ns keeps every link edge off a core clock edge
    task automatic frame(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
        rx = 16'h0000;
        cs_n = 1'b0;
        #80.1;
        for (int i = 0; i < nbits; i++) begin
            sclk = 1'b0;
            sdi = tx[15 - i];
            #62.5;
            sclk = 1'b1;
            rx = {rx[14:0], sdo_wire};
            #62.5;
        end
        cs_n = 1'b1;
        sdi = ~sdi;
        #79.9;
    endtask
    // Clock and data activity while deselected
    // Lead-in keeps edges off core clock edges; tail restores the clock phase
    task automatic idle_toggle(input int n);
        #0.1;
        repeat (n) begin
            sclk = 1'b0;
            sdi = ~sdi;
            #62.5;
            sclk = 1'b1;
            #62.5;
        end
        #3.9;
    endtask
endmodule  // adc_host_model

// File: testbench/adc_serial_port_bench.sv
// Purpose: Self-checking bench for the converter serial host port.
// Assumes: Host model drives the link; bench drives the core side.
// Notes:   Clock enable held high throughout.
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; \
    $display("BAD %0t got %h want %h", $time, a, b); end end
module adc_serial_port_bench;
    import adc_port_pkg::*;
    logic                clk, rst_n, ce, cs_n, sclk, sdi, sdo, sdo_oe, cmd_valid;
    logic                result_ready_strobe;
    logic                int_clock_mode, result_valid;
    logic [RESULT_W-1:0] result_data, rx;
    logic [CMD_W-1:0]    cmd_byte;
    int                  bad_count, n_tests, cmd_seen;
    always #4 clk = ~clk;
    adc_serial_port adc_serial_port_inst (.clk(clk), .rst_n(rst_n), .ce(ce), .cs_n(cs_n),
        .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
        .result_ready_strobe(result_ready_strobe), .int_clock_mode(int_clock_mode),
        .result_valid(result_valid), .result_data(result_data), .cmd_byte(cmd_byte),
        .cmd_valid(cmd_valid));
    adc_host_model adc_host_model_inst (.cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo),
        .sdo_oe(sdo_oe));
    // Count completed bytes
    always @(posedge clk) if (cmd_valid === 1'b1) cmd_seen++;
    // Hand a new result to the port
    task automatic post(input logic [15:0] v);
        @(posedge clk);
        #1 result_data = v;
        result_valid = 1'b1;
        @(posedge clk);
        #1 result_valid = 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask
    // Internal clock mode: strobe, result out, bytes in
    task automatic t_int_read;
        post(16'hA5C3);
        `CHK(result_ready_strobe, 1'b1)
        adc_host_model_inst.frame(16'h1096, 16, rx);
        `CHK(rx, 16'hA5C3)
        `CHK(cmd_byte, 8'h96)
        `CHK(cmd_seen, 2)
        `CHK(result_ready_strobe, 1'b0)
        `CHK(sdo_oe, 1'b0)
    endtask
    // Frames close together with boundary results
    task automatic t_back_to_back;
        post(16'h8001);
        adc_host_model_inst.frame(16'hFF3C, 16, rx);
        `CHK(rx, 16'h8001)
        post(16'hFFFE);
        adc_host_model_inst.frame(16'h00C3, 16, rx);
        `CHK(rx, 16'hFFFE)
        `CHK(cmd_byte, 8'hC3)
    endtask
    // Activity while deselected and a cut-short frame leave no trace
    task automatic t_ignore;
        int seen;
        seen = cmd_seen;
        adc_host_model_inst.idle_toggle(12);
        adc_host_model_inst.frame(16'hF000, 4, rx);
        `CHK(cmd_seen, seen)
        `CHK(cmd_byte, 8'hC3)
        adc_host_model_inst.frame(16'h815A, 16, rx);
        `CHK(cmd_byte, 8'h5A)
        `CHK(cmd_seen, seen + 2)
    endtask
    // External clock mode keeps the strobe low
    task automatic t_ext_mode;
        int_clock_mode = 1'b0;
        post(16'h1234);
        `CHK(result_ready_strobe, 1'b0)
        adc_host_model_inst.frame(16'h00E7, 16, rx);
        `CHK(rx, 16'h1234)
        `CHK(result_ready_strobe, 1'b0)
    endtask
    // Verdict and end of run
    task automatic test_done;
        if (bad_count == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Main sequence
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        ce = 1'b1;
        int_clock_mode = 1'b1;
        result_valid = 1'b0;
        result_data = 16'h0000;
        bad_count = 0;
        n_tests = 0;
        cmd_seen = 0;
        repeat (3) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge clk);
        t_int_read;
        t_back_to_back;
        t_ignore;
        t_ext_mode;
        test_done;
    end
    // Watchdog
    initial begin
        #60000;
        bad_count++;
        test_done;
    end
endmodule  // adc_serial_port_bench
